// ==== hw/sync_pkg.sv ====
// constants, register map and types for the timing front end
// assumes one system clock; offsets are byte addresses on an ahb-lite slave
package sync_pkg;

  // port count and register bus
  localparam int unsigned NPORTS_DEF = 4;
  localparam int unsigned REG_AW     = 8;

  // register offsets
  localparam logic [REG_AW-1:0] OFS_CTRL     = 8'h00;
  localparam logic [REG_AW-1:0] OFS_DOMAIN   = 8'h04;
  localparam logic [REG_AW-1:0] OFS_CLASS    = 8'h08;
  localparam logic [REG_AW-1:0] OFS_FINE     = 8'h0C;
  localparam logic [REG_AW-1:0] OFS_COARSE   = 8'h10;
  localparam logic [REG_AW-1:0] OFS_STATUS   = 8'h14;
  localparam logic [REG_AW-1:0] OFS_REPORT   = 8'h18;
  localparam logic [REG_AW-1:0] OFS_NAV_SEC  = 8'h1C;

  // control bits
  localparam int unsigned CTRL_PARTIAL_BIT = 0;
  localparam int unsigned CTRL_LIST_BIT    = 1;
  localparam int unsigned CTRL_REDUND_BIT  = 2;
  localparam int unsigned CTRL_W           = 3;
  localparam logic [CTRL_W-1:0] CTRL_RST   = 3'h0;

  // status fields
  localparam int unsigned ST_FRAME_LSB = 0;
  localparam int unsigned ST_VALID_BIT = 12;
  localparam int unsigned ST_LOCK_BIT  = 13;
  localparam int unsigned ST_PORT_LSB  = 16;
  localparam int unsigned ST_QUAL_LSB  = 24;

  // announce acceptance
  localparam logic [7:0] DOMAIN_FULL    = 8'h18;
  localparam logic [7:0] DOMAIN_PARTIAL = 8'h2C;
  localparam logic [15:0] DOMAIN_RST    = 16'h2C18;
  localparam int unsigned CLASS_SLOTS   = 7;
  localparam logic [CLASS_SLOTS-1:0] CLASS_MASK_RST = 7'h03;
  localparam logic [7:0] CLASS_VALUES [CLASS_SLOTS] =
    '{8'h06, 8'h07, 8'h87, 8'h8C, 8'h96, 8'hA0, 8'hF8};
  localparam logic [2:0] CLASS_NONE = 3'h7;

  // time conversion
  localparam int unsigned FRAME_W     = 10;
  localparam int unsigned R_W         = 42;
  localparam int unsigned SLOT_QW     = 7;
  localparam logic [47:0] EPOCH_GAP_S = 48'h0000_12D5_3D93;
  localparam logic [FRAME_W-1:0] FRAMES_PER_S = 10'h064;
  localparam logic [FRAME_W-1:0] FRAME_LIMIT  = 10'h3FF;
  localparam logic [R_W-1:0] NS_SCALE    = 42'h000_0000_0300;
  localparam logic [R_W-1:0] FINE_SCALE  = 42'h000_0000_0271;
  localparam logic [R_W-1:0] SLOT_SCALED = 42'h001_C9C3_8000;
  localparam logic [R_W-1:0] SEC_SCALED  = 42'h0B2_D05E_0000;
  localparam logic [23:0] FINE_MAX       = 24'hBB_8000;

  // port selection states
  typedef enum logic [1:0]
  {
    ST_SEARCH = 2'b01,
    ST_LOCKED = 2'b10
  } sel_state_t;

endpackage : sync_pkg

// ==== hw/frame_if.sv ====
// carrier between the register/selection logic and the frame calculator
// assumes one clock domain; the calculator only reads time and offsets
`timescale 1ns/1ps
interface frame_if;
  import sync_pkg::*;
  logic [47:0]        ptp_sec;
  logic [29:0]        ptp_nsec;
  logic               time_valid;
  logic [23:0]        fine;
  logic signed [15:0] coarse;
  logic [FRAME_W-1:0] frame;
  logic               frame_valid;
  logic [31:0]        nav_sec;

  modport calc (input ptp_sec, ptp_nsec, time_valid, fine, coarse,
                output frame, frame_valid, nav_sec);
  modport ctrl (output ptp_sec, ptp_nsec, time_valid, fine, coarse,
                input frame, frame_valid, nav_sec);
endinterface : frame_if

// ==== hw/announce_filter.sv ====
// per-port announce checker: holds whether the last announce was acceptable
// assumes announce fields are stable in the cycle msg_valid_in is high
`timescale 1ns/1ps
module announce_filter
  import sync_pkg::*;
(
  // clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   rst_n_in,
  // received announce
  input  wire logic                   msg_valid_in,
  input  wire logic [7:0]             domain_in,
  input  wire logic [7:0]             class_in,
  // acceptance lists
  input  wire logic                   partial_in,
  input  wire logic                   list_en_in,
  input  wire logic [15:0]            domain_list_in,
  input  wire logic [CLASS_SLOTS-1:0] class_mask_in,
  // result
  output logic                        qualified_out,
  output logic [7:0]                  class_seen_out
);

  // map a class value to its mask slot; anything else has no slot
  function automatic logic [2:0] class_slot(input logic [7:0] c);
    logic [2:0] s;
    s = CLASS_NONE;
    for (int i = 0; i < CLASS_SLOTS; i++)
    begin
      if (c == CLASS_VALUES[i])
        s = 3'(i);
    end
    return s;
  endfunction : class_slot

  logic       domain_ok;
  logic       class_ok;
  logic [2:0] slot;

  // profile default unless software enables its own two-entry list
  always_comb
  begin
    slot = class_slot(class_in);
    if (list_en_in)
      domain_ok = (domain_in == domain_list_in[7:0]) || (domain_in == domain_list_in[15:8]);
    else
      domain_ok = domain_in == (partial_in ? DOMAIN_PARTIAL : DOMAIN_FULL);
    class_ok = (slot != CLASS_NONE) && class_mask_in[slot];
  end

  // each announce refreshes the verdict; a bad one drops the port at once
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      qualified_out  <= 1'b0;
      class_seen_out <= 8'h00;
    end
    else if (msg_valid_in)
    begin
      qualified_out  <= domain_ok && class_ok;
      class_seen_out <= class_in;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_illegal_class_rejected: assert property (msg_valid_in && class_slot(class_in) == CLASS_NONE
    |=> !qualified_out) else $error("unlisted class qualified a port");
  a_default_domain_full: assert property (msg_valid_in && !list_en_in && !partial_in
    && domain_in == DOMAIN_PARTIAL |=> !qualified_out) else $error("wrong profile domain taken");
  a_verdict_holds: assert property (!msg_valid_in |=> $stable(qualified_out))
    else $error("verdict changed without announce");

endmodule : announce_filter

// ==== hw/frame_count_calc.sv ====
// derives the 10 ms frame count from precision time and the two offsets
// two-cycle pipeline; assumes nanoseconds below one second and clamped fine offset
`timescale 1ns/1ps
module frame_count_calc
  import sync_pkg::*;
(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // time, offsets and result
  frame_if.calc     fif
);

  // restoring division by one frame slot; quotient never exceeds 99
  function automatic logic [SLOT_QW-1:0] slot_div(input logic [R_W-1:0] r);
    logic [R_W-1:0]     acc;
    logic [SLOT_QW-1:0] q;
    acc = r;
    q   = '0;
    for (int i = SLOT_QW - 1; i >= 0; i--)
    begin
      if (acc >= (SLOT_SCALED << i))
      begin
        acc  = acc - (SLOT_SCALED << i);
        q[i] = 1'b1;
      end
    end
    return q;
  endfunction : slot_div

  logic [47:0]          nav_sec;
  logic [R_W-1:0]       ns_scaled;
  logic [R_W-1:0]       fine_scaled;
  logic signed [R_W-1:0] rem_raw;
  logic                 borrow;
  logic [2*FRAME_W-1:0] sec_frames;
  logic [FRAME_W-1:0]   base_reg;
  logic [R_W-1:0]       rem_reg;
  logic                 v1_reg;
  logic [FRAME_W-1:0]   frame_reg;
  logic                 fv_reg;
  logic [31:0]          nav_reg;

  // everything in 1/768 ns so the 1.2288 ratio stays integer
  always_comb
  begin
    nav_sec     = fif.ptp_sec - EPOCH_GAP_S;
    ns_scaled   = R_W'(fif.ptp_nsec) * NS_SCALE;
    fine_scaled = R_W'(fif.fine) * FINE_SCALE;
    rem_raw     = signed'(ns_scaled - fine_scaled);
    borrow      = rem_raw < 0;
    sec_frames  = (2*FRAME_W)'(nav_sec[FRAME_W-1:0]) * (2*FRAME_W)'(FRAMES_PER_S);
  end

  // stage one: whole frames from seconds and coarse offset, remainder kept
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      base_reg <= '0;
      rem_reg  <= '0;
      v1_reg   <= 1'b0;
      nav_reg  <= '0;
    end
    else
    begin
      // low bits only: modulo 1024 keeps the count non-negative for free;
      // a borrowed second costs a whole second of frames, not one frame
      base_reg <= sec_frames[FRAME_W-1:0] - (borrow ? FRAMES_PER_S : '0)
                  - fif.coarse[FRAME_W-1:0];
      rem_reg  <= borrow ? R_W'(rem_raw) + SEC_SCALED : R_W'(rem_raw);
      v1_reg   <= fif.time_valid;
      nav_reg  <= nav_sec[31:0];
    end
  end

  // stage two: add frames inside the current second
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      frame_reg <= '0;
      fv_reg    <= 1'b0;
    end
    else
    begin
      frame_reg <= base_reg + FRAME_W'(slot_div(rem_reg));
      fv_reg    <= v1_reg;
    end
  end

  assign fif.frame       = frame_reg;
  assign fif.frame_valid = fv_reg;
  assign fif.nav_sec     = nav_reg;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  logic [FRAME_W-1:0] exp_whole;
  assign exp_whole = sec_frames[FRAME_W-1:0] - fif.coarse[FRAME_W-1:0];

  a_epoch_zero_align: assert property (fif.ptp_sec == EPOCH_GAP_S && fif.ptp_nsec == '0
    && fif.fine == '0 && fif.coarse == '0 |-> ##2 frame_reg == '0)
    else $error("frame not zero at reference instant");
  a_whole_second_map: assert property (fif.time_valid && fif.ptp_nsec == '0 && fif.fine == '0
    |-> ##2 frame_reg == $past(exp_whole, 2)) else $error("frame mismatch on second edge");
  a_valid_latency: assert property (fif.time_valid |-> ##2 fv_reg)
    else $error("frame valid late");
  c_frame_wrap: cover property (frame_reg == FRAME_LIMIT ##1 frame_reg == '0);
  c_negative_coarse: cover property (fif.coarse < 0 && fif.time_valid);

endmodule : frame_count_calc

// ==== hw/sync_announce_frame_number.sv ====
// timing front end: announce qualification, port selection, frame count
// assumes announce and time inputs synchronous to clock_in; one ahb-lite master
`timescale 1ns/1ps
module sync_announce_frame_number
  import sync_pkg::*;
#(
  parameter int unsigned NPORTS = NPORTS_DEF
)
(
  // clock and reset
  input  wire logic                  clock_in,
  input  wire logic                  nrst_in,
  // ahb-lite slave
  input  wire logic                  hsel_in,
  input  wire logic [31:0]           haddr_in,
  input  wire logic [1:0]            htrans_in,
  input  wire logic                  hwrite_in,
  input  wire logic [2:0]            hsize_in,
  input  wire logic [31:0]           hwdata_in,
  input  wire logic                  hready_in,
  output logic [31:0]                hrdata_out,
  output logic                       hreadyout_out,
  output logic                       hresp_out,
  // announce messages, one lane per port
  input  wire logic [NPORTS-1:0]     announce_valid_in,
  input  wire logic [NPORTS*8-1:0]   announce_domain_in,
  input  wire logic [NPORTS*8-1:0]   announce_class_in,
  // precision time from the recovered clock
  input  wire logic [47:0]           ptp_sec_in,
  input  wire logic [29:0]           ptp_nsec_in,
  input  wire logic                  ptp_valid_in,
  // timing outputs
  output logic [FRAME_W-1:0]         system_frame_count_out,
  output logic                       frame_valid_out,
  output logic                       ref_locked_out,
  output logic [$clog2(NPORTS)-1:0]  active_port_out
);

  localparam int unsigned PW = $clog2(NPORTS);

  // lowest qualified port; used for both first lock and switchover
  function automatic logic [PW-1:0] lowest_port(input logic [NPORTS-1:0] v);
    logic [PW-1:0] p;
    p = '0;
    for (int i = NPORTS - 1; i >= 0; i--)
    begin
      if (v[i])
        p = PW'(i);
    end
    return p;
  endfunction : lowest_port

  // reset release through two flops; deassertion is clean, assertion is immediate
  logic [1:0] rst_pipe_reg;
  logic       rst_n;

  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
      rst_pipe_reg <= 2'b00;
    else
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
  end

  assign rst_n = rst_pipe_reg[1];

  // registers
  logic [CTRL_W-1:0]      ctrl_reg;
  logic [15:0]            domain_reg;
  logic [CLASS_SLOTS-1:0] class_mask_reg;
  logic [23:0]            fine_reg;
  logic signed [15:0]     coarse_reg;
  logic                   wr_pend_reg;
  logic [REG_AW-1:0]      wr_addr_reg;
  logic [31:0]            hrdata_reg;
  logic [31:0]            rd_mux;
  logic [31:0]            status_word;
  logic                   addr_ok;

  // selection state
  sel_state_t             state_reg;
  logic [PW-1:0]          active_reg;
  logic                   ever_locked_reg;
  logic [NPORTS-1:0]      qual;
  logic [NPORTS-1:0]      others;
  logic [7:0]             class_seen [NPORTS];

  frame_if fif ();

  // bus: zero wait states, never an error
  assign addr_ok       = hsel_in && htrans_in[1] && hready_in;
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
  assign hrdata_out    = hrdata_reg;

  // address phase capture; the write lands in the data phase
  always_ff @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
    end
    else
    begin
      wr_pend_reg <= addr_ok && hwrite_in;
      wr_addr_reg <= haddr_in[REG_AW-1:0];
    end
  end

  // configuration writes; fine offset beyond one frame is clamped
  always_ff @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_reg       <= CTRL_RST;
      domain_reg     <= DOMAIN_RST;
      class_mask_reg <= CLASS_MASK_RST;
      fine_reg       <= '0;
      coarse_reg     <= '0;
    end
    else if (wr_pend_reg)
    begin
      case (wr_addr_reg)
        OFS_CTRL:   ctrl_reg       <= hwdata_in[CTRL_W-1:0];
        OFS_DOMAIN: domain_reg     <= hwdata_in[15:0];
        OFS_CLASS:  class_mask_reg <= hwdata_in[CLASS_SLOTS-1:0];
        OFS_FINE:   fine_reg       <= (hwdata_in[23:0] > FINE_MAX || hwdata_in[31:24] != 8'h00)
                                      ? FINE_MAX : hwdata_in[23:0];
        OFS_COARSE: coarse_reg     <= hwdata_in[15:0];
        default:    ;
      endcase
    end
  end

  // status word assembly
  always_comb
  begin
    status_word = '0;
    status_word[ST_FRAME_LSB +: FRAME_W] = fif.frame;
    status_word[ST_VALID_BIT]            = fif.frame_valid;
    status_word[ST_LOCK_BIT]             = state_reg == ST_LOCKED;
    status_word[ST_PORT_LSB +: PW]       = active_reg;
    status_word[ST_QUAL_LSB +: NPORTS]   = qual;
  end

  // read mux; unmapped addresses read zero
  always_comb
  begin
    case (haddr_in[REG_AW-1:0])
      OFS_CTRL:    rd_mux = 32'(ctrl_reg);
      OFS_DOMAIN:  rd_mux = 32'(domain_reg);
      OFS_CLASS:   rd_mux = 32'(class_mask_reg);
      OFS_FINE:    rd_mux = 32'(fine_reg);
      OFS_COARSE:  rd_mux = 32'(unsigned'(coarse_reg));
      OFS_STATUS:  rd_mux = status_word;
      OFS_REPORT:  rd_mux = 32'(class_seen[active_reg]);
      OFS_NAV_SEC: rd_mux = fif.nav_sec;
      default:     rd_mux = 32'h0000_0000;
    endcase
  end

  // read data sampled at the address phase so it stands in the data phase
  always_ff @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
      hrdata_reg <= '0;
    else if (addr_ok && !hwrite_in)
      hrdata_reg <= rd_mux;
  end

  // one announce checker per port
  genvar g;
  generate
    for (g = 0; g < NPORTS; g++)
    begin : g_port
      announce_filter u_filter (
        .clk_in         (clock_in),
        .rst_n_in       (rst_n),
        .msg_valid_in   (announce_valid_in[g]),
        .domain_in      (announce_domain_in[g*8 +: 8]),
        .class_in       (announce_class_in[g*8 +: 8]),
        .partial_in     (ctrl_reg[CTRL_PARTIAL_BIT]),
        .list_en_in     (ctrl_reg[CTRL_LIST_BIT]),
        .domain_list_in (domain_reg),
        .class_mask_in  (class_mask_reg),
        .qualified_out  (qual[g]),
        .class_seen_out (class_seen[g])
      );
    end
  endgenerate

  assign others = qual & ~(NPORTS'(1) << active_reg);

  // port selection: any port at startup, redundancy switch when enabled;
  // without redundancy the first chosen port is kept and re-locked only on it
  always_ff @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg       <= ST_SEARCH;
      active_reg      <= '0;
      ever_locked_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_SEARCH:
        begin
          if (!ever_locked_reg || ctrl_reg[CTRL_REDUND_BIT])
          begin
            if (|qual)
            begin
              active_reg      <= lowest_port(qual);
              state_reg       <= ST_LOCKED;
              ever_locked_reg <= 1'b1;
            end
          end
          else if (qual[active_reg])
            state_reg <= ST_LOCKED;
        end
        ST_LOCKED:
        begin
          if (!qual[active_reg])
          begin
            if (ctrl_reg[CTRL_REDUND_BIT] && |others)
              active_reg <= lowest_port(others);
            else
              state_reg <= ST_SEARCH;
          end
        end
        default:
          state_reg <= ST_SEARCH;
      endcase
    end
  end

  // frame calculator wiring
  assign fif.ptp_sec    = ptp_sec_in;
  assign fif.ptp_nsec   = ptp_nsec_in;
  assign fif.time_valid = ptp_valid_in && (state_reg == ST_LOCKED);
  assign fif.fine       = fine_reg;
  assign fif.coarse     = coarse_reg;

  frame_count_calc u_frame (
    .clk_in   (clock_in),
    .rst_n_in (rst_n),
    .fif      (fif)
  );

  assign system_frame_count_out = fif.frame;
  assign frame_valid_out        = fif.frame_valid;
  assign ref_locked_out         = state_reg == ST_LOCKED;
  assign active_port_out        = active_reg;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n);

  a_lock_from_any: assert property (state_reg == ST_SEARCH && !ever_locked_reg && |qual
    |=> state_reg == ST_LOCKED && active_reg == $past(lowest_port(qual)))
    else $error("startup lock missed a qualified port");
  a_redundant_switch: assert property (state_reg == ST_LOCKED && !qual[active_reg]
    && ctrl_reg[CTRL_REDUND_BIT] && |others |=> state_reg == ST_LOCKED
    && active_reg != $past(active_reg)) else $error("redundant switch not taken");
  a_fine_in_range: assert property (fine_reg <= FINE_MAX)
    else $error("fine offset beyond one frame");
  a_class_reset_value: assert property ($rose(rst_n) |-> class_mask_reg == CLASS_MASK_RST)
    else $error("class mask reset wrong");
  c_first_lock: cover property (state_reg == ST_SEARCH ##1 state_reg == ST_LOCKED);
  c_switchover: cover property (state_reg == ST_LOCKED && active_reg != $past(active_reg));
  c_lost_lock: cover property (state_reg == ST_LOCKED ##1 state_reg == ST_SEARCH);

endmodule : sync_announce_frame_number

// ==== dv/timing_master_model.sv ====
// timing master model: announce lanes toward the radio unit
// assumes the bench raises fire_in for exactly one cycle per message
`timescale 1ns/1ps
module timing_master_model #(
  parameter int NP = 4
)
(
  // clock and command from the bench
  input  wire logic            clk_in,
  input  wire logic            fire_in,
  input  wire logic [NP-1:0]   mask_in,
  input  wire logic [7:0]      dom_in,
  input  wire logic [7:0]      cls_in,
  // announce lanes
  output logic      [NP-1:0]   valid_out,
  output logic      [NP*8-1:0] dom_out,
  output logic      [NP*8-1:0] cls_out
);
  initial
  begin
    valid_out = '0;
    dom_out   = '0;
    cls_out   = '0;
  end
  // one pulse on each masked lane; fields toggle outside the pulse so stale data never looks valid
  always @(posedge clk_in)
  begin
    valid_out <= fire_in ? mask_in : '0;
    dom_out   <= fire_in ? {NP{dom_in}} : ~dom_out;
    cls_out   <= fire_in ? {NP{cls_in}} : ~cls_out;
  end
endmodule : timing_master_model

// ==== dv/sync_announce_frame_number_bench.sv ====
// self-checking bench for the timing front end
// assumes zero-wait ahb-lite slave and a 2-cycle frame pipeline
`timescale 1ns/1ps
module sync_announce_frame_number_bench
  import sync_pkg::*;
();
  logic        clock_in = 0, nrst_in = 0, hsel, hwrite, fire, ptp_valid, rdy, fvalid, locked;
  logic        hresp;
  logic [1:0]  htrans, aport;
  logic [2:0]  hsize;
  logic [3:0]  mask, av;
  logic [7:0]  dom, cls;
  logic [9:0]  frame;
  logic [29:0] pnsec;
  logic [31:0] haddr, hwdata, hrdata, ad, ac, rd;
  logic [47:0] psec;
  int          num_errors = 0, check_count = 0;
  logic [7:0]  cl [8] = '{6, 7, 135, 140, 150, 160, 248, 5};
  logic [7:0]  dl [3] = '{24, 44, 33};
  longint      s, ns, fi, co;

  // 20 MHz system clock
  always #25 clock_in = ~clock_in;

  sync_announce_frame_number DUT (
    .clock_in(clock_in), .nrst_in(nrst_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(rdy), .hrdata_out(hrdata), .hreadyout_out(rdy), .hresp_out(hresp),
    .announce_valid_in(av), .announce_domain_in(ad), .announce_class_in(ac),
    .ptp_sec_in(psec), .ptp_nsec_in(pnsec), .ptp_valid_in(ptp_valid),
    .system_frame_count_out(frame), .frame_valid_out(fvalid),
    .ref_locked_out(locked), .active_port_out(aport));

  timing_master_model #(.NP(4)) master (
    .clk_in(clock_in), .fire_in(fire), .mask_in(mask), .dom_in(dom), .cls_in(cls),
    .valid_out(av), .dom_out(ad), .cls_out(ac));

  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    if (got !== exp)
      num_errors++;
  endtask : chk

  // one single transfer; the master holds each phase until hready is seen high
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1; htrans <= 2'b10; haddr <= {24'h00_0000, a}; hwrite <= wr;
    @(posedge clock_in);
    while (rdy !== 1'b1) @(posedge clock_in);
    hsel <= 0; htrans <= 2'b00; hwdata <= wd;
    @(posedge clock_in);
    while (rdy !== 1'b1) @(posedge clock_in);
    rd = hrdata;
    chk(32'(hresp), 32'h0000_0000);
  endtask : bus

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask : rdchk

  // one announce, then time for qualification and lock to settle
  task automatic ann(input logic [3:0] m, input logic [7:0] d, input logic [7:0] c);
    fire <= 1; mask <= m; dom <= d; cls <= c;
    @(posedge clock_in);
    fire <= 0;
    repeat (4) @(posedge clock_in);
  endtask : ann

  // reference frame count in 1/1.2288e13 s units, floor toward minus infinity
  function automatic logic [9:0] fref(input longint s, ns, fi, co);
    longint f, q;
    f = ns * 12288 - fi * 10000;
    q = f / 64'sh1C_9C38_0000;
    if (f < 0 && f % 64'sh1C_9C38_0000 != 0) q--;
    f = (s - 315964819) * 100 - co + q;
    return 10'(((f % 1024) + 1024) % 1024);
  endfunction : fref

  task automatic frm(input longint s, ns, fi, co);
    bus(1, OFS_FINE, 32'(fi));
    bus(1, OFS_COARSE, {16'h0000, 16'(co)});
    psec <= 48'(s); pnsec <= 30'(ns);
    repeat (3) @(posedge clock_in);
    chk(frame, fref(s, ns, fi, co));
    chk(fvalid, 1);
    rdchk(OFS_NAV_SEC, 32'(s - 315964819));
  endtask : frm

  // watchdog: the whole run needs well under 20000 cycles
  initial
  begin
    repeat (20000) @(posedge clock_in);
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict();
  end

  initial
  begin
    void'($urandom(13967));
    hsel = 0; htrans = 0; hwrite = 0; hsize = 3'b010; haddr = 0; hwdata = 0; fire = 0;
    mask = 0; dom = 0; cls = 0; psec = 0; pnsec = 0; ptp_valid = 0;
    repeat (3) @(posedge clock_in);
    nrst_in <= 1;
    repeat (3) @(posedge clock_in);
    // reset values and an unmapped place
    rdchk(OFS_CTRL, 32'h0000_0000);
    rdchk(OFS_DOMAIN, 32'h0000_2C18);
    rdchk(OFS_CLASS, 32'h0000_0003);
    rdchk(8'h40, 32'h0000_0000);
    // first lock goes to the lowest qualified port and then stays there
    ann(4'b1100, 24, 6);
    chk(locked, 1);
    chk(aport, 2);
    ann(4'b0010, 24, 7);
    chk(aport, 2);
    // redundancy: the active port loses its class, the lowest other one takes over
    bus(1, OFS_CTRL, 32'h0000_0004);
    ann(4'b0100, 24, 135);
    chk(aport, 1);
    chk(locked, 1);
    rdchk(OFS_REPORT, 32'h0000_0007);
    // every configurable class under the default and the full mask; class 5 never passes
    for (int k = 0; k < 2; k++)
    begin
      bus(1, OFS_CLASS, k ? 32'h0000_007F : 32'h0000_0003);
      for (int i = 0; i < 8; i++)
      begin
        ann(4'b0001, 24, cl[i]);
        bus(0, OFS_STATUS, 32'h0000_0000);
        chk(rd[24], i < 7 && (k == 1 || i < 2));
      end
    end
    // full default, partial default and own list each take only their domain
    bus(1, OFS_DOMAIN, 32'h0000_2100);
    for (int k = 0; k < 3; k++)
    begin
      bus(1, OFS_CTRL, 32'h0000_0004 + k);
      for (int j = 0; j < 3; j++)
      begin
        ann(4'b0001, dl[j], 6);
        bus(0, OFS_STATUS, 32'h0000_0000);
        chk(rd[24], k == j);
      end
    end
    // fine offset clamps; both offsets read back as raw fields
    bus(1, OFS_FINE, 32'h00FF_FFFF);
    rdchk(OFS_FINE, 32'h00BB_8000);
    bus(1, OFS_COARSE, 32'h0000_8000);
    rdchk(OFS_COARSE, 32'h0000_8000);
    // frame count at the reference, before it, at a slot edge and at the coarse limit
    ptp_valid <= 1;
    frm(315964819, 0, 0, 0);
    frm(315964819, 0, 0, 5);
    frm(315964829, 0, 12288000, 0);
    frm(315964819, 0, 0, -32768);
    // random time and offsets within the host's legal ranges
    repeat (40)
    begin
      s  = 315964819 - 100000000 + longint'($urandom_range(0, 200000000));
      ns = $urandom_range(0, 999999999);
      fi = $urandom_range(0, 12288000);
      co = longint'($urandom_range(0, 65535)) - 32768;
      frm(s, ns, fi, co);
    end
    // an unlisted class on every port drops the lock, and frame valid follows
    ann(4'b1111, 24, 5);
    chk(locked, 0);
    @(posedge clock_in);
    chk(fvalid, 0);
    give_verdict();
  end
endmodule : sync_announce_frame_number_bench
